//--- rtl/rtu_defs.svh
// register offsets, field positions and reset values for the raster timing unit registers
// assumes inclusion by the block's package, design file and host model
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH
`define RTU_IDX_END_HSYNC 5'h05
`define RTU_IDX_VTOTAL 5'h06
`define RTU_IDX_VHIGH 5'h07
`define RTU_IDX_PRESET 5'h08
`define RTU_IDX_MAXSCAN 5'h09
`define RTU_IDX_CUR_FIRST 5'h0a
`define RTU_IDX_CUR_LAST 5'h0b
`define RTU_IDX_ORG_HI 5'h0c
`define RTU_IDX_ORG_LO 5'h0d
`define RTU_IDX_CPOS_HI 5'h0e
`define RTU_IDX_CPOS_LO 5'h0f
`define RTU_IDX_VSYNC_LO 5'h10
`define RTU_IDX_PROT_MAX 5'h07
`define RTU_PORT_MONO_IDX 16'h03b4
`define RTU_PORT_COLOR_IDX 16'h03d4
`define RTU_VHIGH_DISP_MASK 8'h42
`define RTU_VHIGH_LOCK0_MASK 8'had
`define RTU_VHIGH_LC_MASK 8'h10
`define RTU_REG_RESET 8'h00
`endif

//--- rtl/rtu_pkg.sv
// types shared by the raster timing unit register block
// assumes the defs header sits beside it
`include "rtu_defs.svh"
package rtu_pkg;
    typedef enum logic [1:0] {
        RTU_SKEW_0 = 2'b00,
        RTU_SKEW_1 = 2'b01,
        RTU_SKEW_2 = 2'b10,
        RTU_SKEW_3 = 2'b11
    } rtu_skew_t;
endpackage

//--- rtl/rtu_vtiming_regs.sv
// raster timing unit: vertical timing, cursor and start address registers with row scan logic
// assumes io strobes are synchronous to core_clk, one character clock per char_tick cycle
//
// Contract
// RULE_01 - delay horizontal sync by 0..3 character clocks from end-sync delay field
// RULE_02 - end horizontal sync when low five counter bits equal end field
// RULE_03 - end-sync bit 7 is sixth bit of blanking end compare
// RULE_04 - frame line total is ten bits from total and high-bits register
// RULE_05 - high-bits register holds ninth and tenth bits in documented order
// RULE_06 - legacy mode uses seven-bit row total, bit 7 reserved
// RULE_07 - total register writes ignored when protect bit 0 or write-protect set
// RULE_08 - display-end bits blocked only when protect bit 1 clear and write-protect set
// RULE_09 - high bits 7,5,3,2,0 blocked when protect bit 0 or write-protect set
// RULE_10 - byte panning field shifts data left 0..3 bytes in multi-shift modes
// RULE_11 - row scan counter loads preset once after each vertical sync
// RULE_12 - row scan increments per horizontal sync, clears at maximum
// RULE_13 - line doubling clocks row scan at half horizontal rate
// RULE_14 - max-scan bit 6 is line compare bit 9, bit 5 blank start bit 9
// RULE_15 - max scan field is lines per row minus one, legacy uppers reserved
// RULE_16 - cursor control bit zero shows cursor, one hides it
// RULE_17 - cursor starts at start row; none when start exceeds end
// RULE_18 - cursor active through end row inclusive
// RULE_19 - cursor delayed right 0..3 character clocks by skew field
// RULE_20 - start address extended to 18 bits by protect bits 3 and 4
// RULE_21 - legacy mode forces start address high bits 7:6 to zero
// RULE_22 - cursor location 18 bits in standard mode, six high bits legacy
// RULE_23 - write-protect blocks indexes 00..07 except line compare bit; code leaves index 07 bits 6 and 1 writable when protect bit 1 set
// RULE_24 - index port selects register reached by the data port
// RULE_25 - ports decode mono range when misc bit 0 clear, color when set
// RULE_26 - register values reach counters at next character clock
// RULE_27 - reserved bits read zero and ignore writes
`include "rtu_defs.svh"
module rtu_vtiming_regs #(
    parameter int ROW_W = 5
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic misc_color_sel,
    input wire logic [7:0] vendor_protect_reg_three,
    input wire logic write_protect,
    input wire logic legacy_mode,
    input wire logic multi_shift_mode,
    input wire logic char_tick,
    input wire logic [7:0] hchar_count,
    input wire logic hsync_raw,
    input wire logic hsync_end_pulse,
    input wire logic vsync_end_pulse,
    input wire logic cursor_raw,
    output logic [7:0] io_rdata,
    output logic hsync_out,
    output logic hsync_off_match,
    output logic [5:0] hblank_end_cmp,
    output logic [9:0] frame_line_total,
    output logic [7:0] vhigh_bits,
    output logic [1:0] byte_pan,
    output logic [ROW_W-1:0] row_scan,
    output logic [1:0] vextra_bits,
    output logic cursor_row_active,
    output logic cursor_out,
    output logic [17:0] screen_origin,
    output logic [17:0] cursor_position
);
    logic [7:0] end_hsync_q, vtotal_q, vhigh_q, preset_q, maxscan_q;
    logic [7:0] cfirst_q, clast_q, org_hi_q, org_lo_q, cpos_hi_q, cpos_lo_q, vsync_lo_q;
    logic [4:0] index_q;
    logic [2:0] hs_pipe_q;
    logic [2:0] cur_pipe_q;
    logic dbl_phase_q;
    logic [ROW_W-1:0] row_q;

    // index/data port decode by misc color select
    logic [15:0] base;
    logic idx_hit, dat_hit, prot_idx, lock0;
    assign base = misc_color_sel ? `RTU_PORT_COLOR_IDX : `RTU_PORT_MONO_IDX; // RULE_25
    assign idx_hit = io_addr == base;
    assign dat_hit = io_addr == base + 16'h0001;
    assign prot_idx = write_protect && (index_q <= `RTU_IDX_PROT_MAX); // RULE_23
    assign lock0 = vendor_protect_reg_three[0] || write_protect;

    // write mask for the high-bits register
    function automatic logic [7:0] vhigh_mask(input logic p0, input logic p1, input logic wp);
        logic [7:0] m;
        m = 8'hff;
        if (p0 || wp) begin
            m = m & ~`RTU_VHIGH_LOCK0_MASK; // RULE_09
        end
        if (!p1 && wp) begin
            m = m & ~`RTU_VHIGH_DISP_MASK; // RULE_08
        end
        return m;
    endfunction

    // index register write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            index_q <= 5'h00;
        end else if (io_wr && idx_hit) begin
            index_q <= io_wdata[4:0]; // RULE_24
        end
    end

    // data register writes with locks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            end_hsync_q <= `RTU_REG_RESET;
            vtotal_q <= `RTU_REG_RESET;
            vhigh_q <= `RTU_REG_RESET;
            preset_q <= `RTU_REG_RESET;
            maxscan_q <= `RTU_REG_RESET;
            cfirst_q <= `RTU_REG_RESET;
            clast_q <= `RTU_REG_RESET;
            org_hi_q <= `RTU_REG_RESET;
            org_lo_q <= `RTU_REG_RESET;
            cpos_hi_q <= `RTU_REG_RESET;
            cpos_lo_q <= `RTU_REG_RESET;
            vsync_lo_q <= `RTU_REG_RESET;
        end else if (io_wr && dat_hit) begin
            unique case (index_q)
                `RTU_IDX_END_HSYNC: if (!prot_idx) end_hsync_q <= io_wdata; // RULE_23
                `RTU_IDX_VTOTAL: if (!lock0) vtotal_q <= io_wdata; // RULE_07
                `RTU_IDX_VHIGH: begin
                    vhigh_q <= (io_wdata & vhigh_mask(vendor_protect_reg_three[0],
                        vendor_protect_reg_three[1], write_protect))
                        | (vhigh_q & ~vhigh_mask(vendor_protect_reg_three[0],
                        vendor_protect_reg_three[1], write_protect)); // RULE_05
                end
                `RTU_IDX_PRESET: preset_q <= {1'b0, io_wdata[6:0]}; // RULE_27
                `RTU_IDX_MAXSCAN: begin
                    maxscan_q[7:6] <= io_wdata[7:6];
                    maxscan_q[4:0] <= io_wdata[4:0];
                    if (!vendor_protect_reg_three[0]) maxscan_q[5] <= io_wdata[5];
                end
                `RTU_IDX_CUR_FIRST: cfirst_q <= {2'b00, io_wdata[5:0]}; // RULE_27
                `RTU_IDX_CUR_LAST: clast_q <= {1'b0, io_wdata[6:0]}; // RULE_27
                `RTU_IDX_ORG_HI: org_hi_q <= io_wdata;
                `RTU_IDX_ORG_LO: org_lo_q <= io_wdata;
                `RTU_IDX_CPOS_HI: cpos_hi_q <= io_wdata;
                `RTU_IDX_CPOS_LO: cpos_lo_q <= io_wdata;
                `RTU_IDX_VSYNC_LO: if (!vendor_protect_reg_three[0]) vsync_lo_q <= io_wdata;
                default: ;
            endcase
        end
    end

    // readback of the indexed register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= 8'h00;
        end else if (io_rd && idx_hit) begin
            io_rdata <= {3'b000, index_q};
        end else if (io_rd && dat_hit) begin
            unique case (index_q)
                `RTU_IDX_END_HSYNC: io_rdata <= end_hsync_q;
                `RTU_IDX_VTOTAL: io_rdata <= vtotal_q;
                `RTU_IDX_VHIGH: io_rdata <= vhigh_q;
                `RTU_IDX_PRESET: io_rdata <= preset_q;
                `RTU_IDX_MAXSCAN: io_rdata <= maxscan_q;
                `RTU_IDX_CUR_FIRST: io_rdata <= cfirst_q;
                `RTU_IDX_CUR_LAST: io_rdata <= clast_q;
                `RTU_IDX_ORG_HI: io_rdata <= org_hi_q;
                `RTU_IDX_ORG_LO: io_rdata <= org_lo_q;
                `RTU_IDX_CPOS_HI: io_rdata <= cpos_hi_q;
                `RTU_IDX_CPOS_LO: io_rdata <= cpos_lo_q;
                `RTU_IDX_VSYNC_LO: io_rdata <= vsync_lo_q;
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    // snapshot of register fields into the counter domain on a character clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hblank_end_cmp <= 6'h00;
            frame_line_total <= 10'h000;
            vhigh_bits <= 8'h00;
            byte_pan <= 2'b00;
            vextra_bits <= 2'b00;
            screen_origin <= 18'h0_0000;
            cursor_position <= 18'h0_0000;
        end else if (char_tick) begin // RULE_26
            hblank_end_cmp <= {end_hsync_q[7], 5'h00}; // RULE_03
            frame_line_total <= legacy_mode ? {3'b000, vtotal_q[6:0]}
                : {vhigh_q[5], vhigh_q[0], vtotal_q}; // RULE_04 RULE_06
            vhigh_bits <= vhigh_q;
            byte_pan <= multi_shift_mode ? preset_q[6:5] : 2'b00; // RULE_10
            vextra_bits <= legacy_mode ? 2'b00 : maxscan_q[6:5]; // RULE_14 RULE_15
            screen_origin <= {vendor_protect_reg_three[4:3],
                legacy_mode ? 2'b00 : org_hi_q[7:6], org_hi_q[5:0], org_lo_q}; // RULE_20 RULE_21
            cursor_position <= legacy_mode ? {4'h0, cpos_hi_q[5:0], cpos_lo_q}
                : {vendor_protect_reg_three[4:3], cpos_hi_q, cpos_lo_q}; // RULE_22
        end
    end

    // horizontal sync delay line and end match
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_pipe_q <= 3'b000;
            hsync_out <= 1'b0;
            hsync_off_match <= 1'b0;
        end else if (char_tick) begin
            hs_pipe_q <= {hs_pipe_q[1:0], hsync_raw};
            unique case (rtu_pkg::rtu_skew_t'(end_hsync_q[6:5])) // RULE_01
                rtu_pkg::RTU_SKEW_0: hsync_out <= hsync_raw;
                rtu_pkg::RTU_SKEW_1: hsync_out <= hs_pipe_q[0];
                rtu_pkg::RTU_SKEW_2: hsync_out <= hs_pipe_q[1];
                rtu_pkg::RTU_SKEW_3: hsync_out <= hs_pipe_q[2];
            endcase
            hsync_off_match <= hchar_count[4:0] == end_hsync_q[4:0]; // RULE_02
        end
    end

    // row scan counter with preset, wrap and line doubling
    logic [ROW_W-1:0] row_max;
    assign row_max = maxscan_q[ROW_W-1:0];
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            row_q <= '0;
            dbl_phase_q <= 1'b0;
        end else if (vsync_end_pulse) begin
            row_q <= preset_q[ROW_W-1:0]; // RULE_11
            dbl_phase_q <= 1'b0;
        end else if (hsync_end_pulse) begin
            dbl_phase_q <= maxscan_q[7] ? !dbl_phase_q : 1'b0; // RULE_13
            if (!maxscan_q[7] || dbl_phase_q) begin
                row_q <= (row_q >= row_max) ? '0 : row_q + 1'b1; // RULE_12
            end
        end
    end
    assign row_scan = row_q;

    // cursor row window and skew delay
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cursor_row_active <= 1'b0;
            cur_pipe_q <= 3'b000;
            cursor_out <= 1'b0;
        end else if (char_tick) begin
            cursor_row_active <= !cfirst_q[5] && (cfirst_q[4:0] <= clast_q[4:0])
                && (5'(row_q) >= cfirst_q[4:0]) && (5'(row_q) <= clast_q[4:0]); // RULE_16 RULE_17 RULE_18
            cur_pipe_q <= {cur_pipe_q[1:0], cursor_raw && cursor_row_active};
            unique case (rtu_pkg::rtu_skew_t'(clast_q[6:5])) // RULE_19
                rtu_pkg::RTU_SKEW_0: cursor_out <= cursor_raw && cursor_row_active;
                rtu_pkg::RTU_SKEW_1: cursor_out <= cur_pipe_q[0];
                rtu_pkg::RTU_SKEW_2: cursor_out <= cur_pipe_q[1];
                rtu_pkg::RTU_SKEW_3: cursor_out <= cur_pipe_q[2];
            endcase
        end
    end

    property p_vtotal_lock;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_VTOTAL && lock0) |=> $stable(vtotal_q);
    endproperty
    a_vtotal_lock: assert property (p_vtotal_lock) else $error("total written while locked"); // RULE_07

    property p_disp_lock;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_VHIGH && !vendor_protect_reg_three[1] && write_protect)
        |=> (vhigh_q[6] == $past(vhigh_q[6])) && (vhigh_q[1] == $past(vhigh_q[1]));
    endproperty
    a_disp_lock: assert property (p_disp_lock) else $error("display end bits changed"); // RULE_08

    property p_lc_free;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_VHIGH) |=> vhigh_q[4] == $past(io_wdata[4]);
    endproperty
    a_lc_free: assert property (p_lc_free) else $error("line compare bit not written"); // RULE_23

    property p_preset;
        @(posedge core_clk) disable iff (!arst_n)
        vsync_end_pulse |=> row_q == $past(preset_q[ROW_W-1:0]);
    endproperty
    a_preset: assert property (p_preset) else $error("row preset not loaded"); // RULE_11

    property p_wrap;
        @(posedge core_clk) disable iff (!arst_n)
        (hsync_end_pulse && !vsync_end_pulse && !maxscan_q[7] && row_q >= row_max) |=> row_q == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("row scan did not clear"); // RULE_12

    property p_double;
        @(posedge core_clk) disable iff (!arst_n)
        (hsync_end_pulse && !vsync_end_pulse && maxscan_q[7] && !dbl_phase_q) |=> $stable(row_q);
    endproperty
    a_double: assert property (p_double) else $error("row advanced on first of doubled line"); // RULE_13

    property p_cursor_off;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && cfirst_q[5]) |=> !cursor_row_active;
    endproperty
    a_cursor_off: assert property (p_cursor_off) else $error("cursor shown while disabled"); // RULE_16

    property p_index;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && idx_hit) |=> index_q == $past(io_wdata[4:0]);
    endproperty
    a_index: assert property (p_index) else $error("index not taken"); // RULE_24

    // lock, readback and field checks
    property p_hs_lock;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_END_HSYNC && write_protect) |=> $stable(end_hsync_q);
    endproperty
    a_hs_lock: assert property (p_hs_lock) else $error("end sync written while protected"); // RULE_23

    property p_lock0_bits;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_VHIGH && lock0)
        |=> (vhigh_q & `RTU_VHIGH_LOCK0_MASK) == ($past(vhigh_q) & `RTU_VHIGH_LOCK0_MASK);
    endproperty
    a_lock0_bits: assert property (p_lock0_bits) else $error("locked high bits changed"); // RULE_09

    property p_rd_index;
        @(posedge core_clk) disable iff (!arst_n)
        (io_rd && idx_hit) |=> io_rdata == {3'b000, $past(index_q)};
    endproperty
    a_rd_index: assert property (p_rd_index) else $error("index readback wrong"); // RULE_24

    property p_preset_rsv;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_PRESET) |=> !preset_q[7];
    endproperty
    a_preset_rsv: assert property (p_preset_rsv) else $error("reserved preset bit stored"); // RULE_27

    property p_maxscan5;
        @(posedge core_clk) disable iff (!arst_n)
        (io_wr && dat_hit && index_q == `RTU_IDX_MAXSCAN && vendor_protect_reg_three[0]) |=> $stable(maxscan_q[5]);
    endproperty
    a_maxscan5: assert property (p_maxscan5) else $error("blank start bit 9 written while locked"); // RULE_14

    property p_hoff;
        @(posedge core_clk) disable iff (!arst_n)
        char_tick |=> hsync_off_match == ($past(hchar_count[4:0]) == $past(end_hsync_q[4:0]));
    endproperty
    a_hoff: assert property (p_hoff) else $error("sync end match wrong"); // RULE_02

    property p_hsync0;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && end_hsync_q[6:5] == 2'b00) |=> hsync_out == $past(hsync_raw);
    endproperty
    a_hsync0: assert property (p_hsync0) else $error("undelayed sync wrong"); // RULE_01

    property p_flt;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && !legacy_mode) |=> frame_line_total == {$past(vhigh_q[5]), $past(vhigh_q[0]), $past(vtotal_q)};
    endproperty
    a_flt: assert property (p_flt) else $error("frame line total wrong"); // RULE_04

    property p_legacy_org;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && legacy_mode) |=> screen_origin[15:14] == 2'b00;
    endproperty
    a_legacy_org: assert property (p_legacy_org) else $error("legacy origin bits not forced"); // RULE_21

    property p_legacy_extra;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && legacy_mode) |=> vextra_bits == 2'b00;
    endproperty
    a_legacy_extra: assert property (p_legacy_extra) else $error("legacy extra bits not zero"); // RULE_15

    property p_pan;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && !multi_shift_mode) |=> byte_pan == 2'b00;
    endproperty
    a_pan: assert property (p_pan) else $error("panning outside multi-shift mode"); // RULE_10

    property p_cursor_window;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && cfirst_q[4:0] > clast_q[4:0]) |=> !cursor_row_active;
    endproperty
    a_cursor_window: assert property (p_cursor_window) else $error("cursor with start past end"); // RULE_17

    property p_cursor_skew0;
        @(posedge core_clk) disable iff (!arst_n)
        (char_tick && clast_q[6:5] == 2'b00) |=> cursor_out == ($past(cursor_raw) && $past(cursor_row_active));
    endproperty
    a_cursor_skew0: assert property (p_cursor_skew0) else $error("unskewed cursor wrong"); // RULE_19
endmodule // rtu_vtiming_regs

//--- verif/rtu_host_model.sv
// host side model: index and data port cycles toward the timing registers
// assumes the bench calls its tasks; strobes change at falling clock edges
`include "rtu_defs.svh"
module rtu_host_model (
    input wire logic core_clk,
    input wire logic color,
    input wire logic [7:0] io_rdata,
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // one strobe held over one rising edge, then lines scrambled
    task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        @(negedge core_clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
    // index port follows the colour select level
    function automatic logic [15:0] base();
        return color ? `RTU_PORT_COLOR_IDX : `RTU_PORT_MONO_IDX;
    endfunction
    // index first, then the data port reaches that register
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        cyc(base(), 1'b1, {3'h0, i});
        cyc(base() + 16'h0001, 1'b1, d);
    endtask
    // read data is taken once it has settled after the read strobe
    task automatic rd(input logic [4:0] i, output logic [7:0] d);
        cyc(base(), 1'b1, {3'h0, i});
        cyc(base() + 16'h0001, 1'b0, 8'h00);
        @(negedge core_clk);
        d = io_rdata;
    endtask
endmodule // rtu_host_model

//--- verif/tb_top.sv
// self-checking bench for the raster timing unit register block
// assumes the host model drives io strobes; timing inputs driven here
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] i; logic [7:0] w; logic [7:0] r;} rtu_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic color = 1'b0;
    logic [7:0] prot = 8'h10;
    logic wp = 1'b0;
    logic legacy = 1'b0;
    logic [7:0] hcnt = 8'h00;
    logic hraw = 1'b0;
    logic hend = 1'b0;
    logic vend = 1'b0;
    logic craw = 1'b0;
    logic cur_o;
    logic [1:0] vext;
    logic [7:0] vhb;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic hsync_out;
    logic hoff;
    logic [5:0] hblank;
    logic [9:0] flt;
    logic [4:0] row;
    logic crow;
    logic [17:0] org;
    logic [17:0] cpos;
    logic [1:0] pan;
    logic [7:0] rv;
    int num_errors = 0;
    int total_checks = 0;
    int lat[4];
    // index, written value, expected read back
    rtu_row_t rows[12] = '{'{5'h05, 8'hca, 8'hca}, '{5'h06, 8'hd5, 8'hd5}, '{5'h07, 8'h21, 8'h21},
        '{5'h08, 8'he3, 8'h63}, '{5'h09, 8'h03, 8'h03}, '{5'h0a, 8'hc1, 8'h01}, '{5'h0b, 8'h82, 8'h02},
        '{5'h0c, 8'hd2, 8'hd2}, '{5'h0d, 8'h34, 8'h34}, '{5'h0e, 8'hd6, 8'hd6}, '{5'h0f, 8'h78, 8'h78},
        '{5'h1f, 8'hff, 8'h00}};
    rtu_vtiming_regs dut (.core_clk(core_clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .misc_color_sel(color), .vendor_protect_reg_three(prot),
        .write_protect(wp), .legacy_mode(legacy), .multi_shift_mode(1'b1), .char_tick(1'b1),
        .hchar_count(hcnt), .hsync_raw(hraw), .hsync_end_pulse(hend), .vsync_end_pulse(vend),
        .cursor_raw(craw), .io_rdata(io_rdata), .hsync_out(hsync_out), .hsync_off_match(hoff),
        .hblank_end_cmp(hblank), .frame_line_total(flt), .vhigh_bits(vhb), .byte_pan(pan), .row_scan(row),
        .vextra_bits(vext), .cursor_row_active(crow), .cursor_out(cur_o), .screen_origin(org),
        .cursor_position(cpos));
    rtu_host_model host (.core_clk(core_clk), .color(color), .io_rdata(io_rdata), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
    // 125 MHz clock
    always #4 core_clk = ~core_clk;
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one-cycle end-of-sync pulse, then let the counter settle
    task automatic pulse(input logic v);
        @(negedge core_clk);
        vend = v;
        hend = !v;
        @(negedge core_clk);
        vend = 1'b0;
        hend = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rdchk(input logic [4:0] i, input logic [7:0] e);
        host.rd(i, rv);
        chk(rv, e);
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        arst_n = 1'b1;
        chk(flt, 10'h000);
        chk(row, 5'h00);
        foreach (rows[k]) begin
            host.wr(rows[k].i, rows[k].w);
            rdchk(rows[k].i, rows[k].r);
        end
        repeat (2) @(negedge core_clk);
        chk(flt, 10'h3d5);
        chk(org, 18'h2_d234);
        chk(cpos, 18'h2_d678);
        chk(pan, 2'h3);
        chk(hblank, 6'h20);
        legacy = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(org[15:0], 16'h1234);
        chk(cpos[15:0], 16'h1678);
        chk(flt[7:0], 8'h55);
        legacy = 1'b0;
        hcnt = 8'h2a;
        repeat (2) @(negedge core_clk);
        chk(hoff, 1'b1);
        hcnt = 8'h2b;
        repeat (2) @(negedge core_clk);
        chk(hoff, 1'b0);
        // sync delay measured against the zero setting
        for (int d = 0; d < 4; d++) begin
            host.wr(5'h05, {1'b1, d[1:0], 5'h0a});
            hraw = 1'b1;
            lat[d] = 0;
            while (hsync_out !== 1'b1 && lat[d] < 20) begin
                @(negedge core_clk);
                lat[d]++;
            end
            if (lat[d] >= 20) begin
                num_errors++;
                wrap_up();
            end
            hraw = 1'b0;
            repeat (8) @(negedge core_clk);
            chk(lat[d] - lat[0], d);
        end
        // row counter: preset 3, maximum 3, cursor rows 1..2
        pulse(1'b1);
        chk(row, 5'h03);
        for (int n = 0; n < 5; n++) begin
            pulse(1'b0);
            chk(row, n % 4);
            chk(crow, n == 1 || n == 2);
        end
        host.wr(5'h09, 8'h83);
        pulse(1'b1);
        pulse(1'b0);
        pulse(1'b0);
        chk(row, 5'h00);
        pulse(1'b0);
        pulse(1'b0);
        chk(row, 5'h01);
        // write locks
        wp = 1'b1;
        prot = 8'h12;
        host.wr(5'h06, 8'haa);
        rdchk(5'h06, 8'hd5);
        host.wr(5'h07, 8'h52);
        rdchk(5'h07, 8'h73);
        prot = 8'h10;
        host.wr(5'h07, 8'h00);
        rdchk(5'h07, 8'h63);
        wp = 1'b0;
        prot = 8'h11;
        host.wr(5'h06, 8'h00);
        rdchk(5'h06, 8'hd5);
        host.wr(5'h07, 8'h00);
        rdchk(5'h07, 8'h21);
        chk(vhb, 8'h21);
        prot = 8'h10;
        // mono ports ignored while colour range selected
        color = 1'b1;
        host.cyc(16'h03b4, 1'b1, 8'h06);
        host.cyc(16'h03b5, 1'b1, 8'h00);
        rdchk(5'h06, 8'hd5);
        host.wr(5'h0d, 8'h99);
        rdchk(5'h0d, 8'h99);
        // cursor skew against the zero setting, row 1 inside rows 1..2
        host.wr(5'h09, 8'h63);
        for (int d = 0; d < 4; d++) begin
            host.wr(5'h0b, {1'b0, d[1:0], 5'h02});
            craw = 1'b1;
            lat[d] = 0;
            while (cur_o !== 1'b1 && lat[d] < 20) begin
                @(negedge core_clk);
                lat[d]++;
            end
            if (lat[d] >= 20) begin
                num_errors++;
                wrap_up();
            end
            craw = 1'b0;
            repeat (8) @(negedge core_clk);
            chk(lat[d] - lat[0], d);
        end
        chk(vext, 2'h3);
        chk(crow, 1'b1);
        host.wr(5'h0a, 8'h21);
        repeat (2) @(negedge core_clk);
        chk(crow, 1'b0);
        // reset in mid-run clears stored registers
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        chk(row, 5'h00);
        rdchk(5'h06, 8'h00);
        wrap_up();
    end
endmodule // tb_top
